// ---- verilog/ppg_pkg.sv ----
// Constants for the cascaded pulse generator and warm-up timer
package ppg_pkg;

    localparam int          REG_AW          = 5;
    localparam logic [4:0]  OFF_LOW_CTL     = 5'h00;
    localparam logic [4:0]  OFF_UP_CTL      = 5'h04;
    localparam logic [4:0]  OFF_PER_LO      = 5'h08;
    localparam logic [4:0]  OFF_PER_HI      = 5'h0C;
    localparam logic [4:0]  OFF_WID_LO      = 5'h10;
    localparam logic [4:0]  OFF_WID_HI      = 5'h14;
    localparam logic [4:0]  OFF_STATUS      = 5'h18;
    localparam logic [4:0]  OFF_COUNT       = 5'h1C;

    // Upper control fields
    localparam int          UP_START_BIT    = 7;
    localparam int          UP_RUN_BIT      = 3;
    localparam int          UP_MODE_LSB     = 0;
    localparam logic [2:0]  MODE_PULSE      = 3'h7;
    localparam logic [2:0]  MODE_WARMUP     = 3'h5;

    // Lower control source select field
    localparam int          LOW_SRC_LSB     = 4;
    localparam logic [2:0]  SRC_DIV2K11     = 3'h0;
    localparam logic [2:0]  SRC_DIV2K7      = 3'h1;
    localparam logic [2:0]  SRC_DIV2K5      = 3'h2;
    localparam logic [2:0]  SRC_DIV2K3      = 3'h3;
    localparam logic [2:0]  SRC_SLOW        = 3'h4;
    localparam logic [2:0]  SRC_DIV2        = 3'h5;
    localparam logic [2:0]  SRC_DIRECT      = 3'h6;
    localparam logic [2:0]  SRC_EXTERNAL    = 3'h7;
    localparam int          PRE_W           = 11;

    // Status fields
    localparam int          ST_FLOP_BIT     = 0;
    localparam int          ST_RUN_BIT      = 1;

    // Values after reset
    localparam logic [7:0]  RST_CTL         = 8'h00;
    localparam logic [7:0]  RST_CMP         = 8'hFF;
    localparam logic [15:0] RST_COUNT       = 16'h0000;
    localparam logic [PRE_W-1:0] RST_PRE    = 11'h000;

    // Warm-up span on a 32768 Hz slow source
    localparam int          SLOW_HZ         = 32768;
    localparam int          WARM_MIN_SET    = 16'h0100;
    localparam int          WARM_MIN_US     = 7810;
    localparam int          WARM_MAX_SET    = 16'hFF00;
    localparam int          WARM_MAX_MS     = 1990;

endpackage

// ---- verilog/count_sync.sv ----
// Two-flop synchroniser with falling edge pulse for the count pin
`timescale 1ns/100ps
module count_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.s2;
    assign fall  = st_r.s3 & ~st_r.s2;
endmodule // count_sync

// ---- verilog/cascaded_ppg_warmup_timer.sv ----
// Cascaded 16-bit pulse generator and warm-up counter with Wishbone registers
`timescale 1ns/100ps
module cascaded_ppg_warmup_timer (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        slow_tick,
    input  wire logic        count_pin,
    output logic             pulse_out_pin,
    output logic             cascade_match_irq
);

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [7:0]  lower_timer_control;
        logic [7:0]  upper_timer_control;
        logic [7:0]  period_low_byte;
        logic [7:0]  period_high_byte;
        logic [7:0]  width_low_byte;
        logic [7:0]  width_high_byte;
        logic [15:0] count;
        logic        output_flop;
        logic        irq;
        logic [ppg_pkg::PRE_W-1:0] pre;
    } timer_t;

    timer_t st_r;
    timer_t st_nxt;

    logic ext_fall;

    count_sync u_count_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  (count_pin),
        .level   (),
        .fall    (ext_fall)
    );

    logic                      req;
    logic                      wr_take;
    logic [ppg_pkg::REG_AW-1:0] adr;
    logic [2:0]                src;
    logic [2:0]                mode;
    logic                      run;
    logic                      tick;
    logic [15:0]               period;
    logic [15:0]               width;
    logic [15:0]               cnt_inc;
    logic                      pulse_mode;
    logic                      warm_mode;
    logic                      per_hit;
    logic                      wid_hit;
    logic                      warm_hit;
    logic                      ctl_write;
    logic [7:0]                wbyte;
    logic [31:0]               rd_val;

    assign req   = wb_cyc_i & wb_stb_i;
    assign adr   = wb_adr_i[ppg_pkg::REG_AW-1:0];
    assign wbyte = wb_dat_i[7:0];
    assign wr_take = req & wb_we_i & st_r.ack & wb_sel_i[0];

    assign src  = st_r.lower_timer_control[ppg_pkg::LOW_SRC_LSB +: 3];
    assign mode = st_r.upper_timer_control[ppg_pkg::UP_MODE_LSB +: 3];
    assign run  = st_r.upper_timer_control[ppg_pkg::UP_RUN_BIT];

    assign pulse_mode = (mode == ppg_pkg::MODE_PULSE);
    assign warm_mode  = (mode == ppg_pkg::MODE_WARMUP);

    // Compare values are read live, with no shadow stage
    assign period = {st_r.period_high_byte, st_r.period_low_byte};
    assign width  = {st_r.width_high_byte, st_r.width_low_byte};

    assign cnt_inc = st_r.count + 16'h0001;

    assign per_hit  = (cnt_inc == period);
    assign wid_hit  = (cnt_inc == width);
    assign warm_hit = (cnt_inc[15:8] == st_r.period_high_byte);

    assign ctl_write = wr_take && (adr == ppg_pkg::OFF_UP_CTL);

    // Source tick selection
    always_comb begin
        tick = 1'b0;
        case (src)
            ppg_pkg::SRC_DIV2K11: begin
                tick = &st_r.pre[10:0];
            end
            ppg_pkg::SRC_DIV2K7: begin
                tick = &st_r.pre[6:0];
            end
            ppg_pkg::SRC_DIV2K5: begin
                tick = &st_r.pre[4:0];
            end
            ppg_pkg::SRC_DIV2K3: begin
                tick = &st_r.pre[2:0];
            end
            ppg_pkg::SRC_SLOW: begin
                tick = slow_tick;
            end
            ppg_pkg::SRC_DIV2: begin
                tick = st_r.pre[0];
            end
            ppg_pkg::SRC_DIRECT: begin
                tick = 1'b1;
            end
            ppg_pkg::SRC_EXTERNAL: begin
                tick = ext_fall;
            end
            default: begin
                tick = 1'b0;
            end
        endcase
    end

    // Read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        case (adr)
            ppg_pkg::OFF_LOW_CTL: begin
                rd_val[7:0] = st_r.lower_timer_control;
            end
            ppg_pkg::OFF_UP_CTL: begin
                rd_val[7:0] = st_r.upper_timer_control;
            end
            ppg_pkg::OFF_PER_LO: begin
                rd_val[7:0] = st_r.period_low_byte;
            end
            ppg_pkg::OFF_PER_HI: begin
                rd_val[7:0] = st_r.period_high_byte;
            end
            ppg_pkg::OFF_WID_LO: begin
                rd_val[7:0] = st_r.width_low_byte;
            end
            ppg_pkg::OFF_WID_HI: begin
                rd_val[7:0] = st_r.width_high_byte;
            end
            ppg_pkg::OFF_STATUS: begin
                rd_val[ppg_pkg::ST_FLOP_BIT] = st_r.output_flop;
                rd_val[ppg_pkg::ST_RUN_BIT]  = run;
            end
            ppg_pkg::OFF_COUNT: begin
                rd_val[15:0] = st_r.count;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // Next state
    always_comb begin
        st_nxt     = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.pre = st_r.pre + 11'h001;

        // Bus slave: ack one cycle after request, drop after
        st_nxt.ack = req & ~st_r.ack;
        if (req && !st_r.ack) begin
            st_nxt.rdata = rd_val;
        end

        if (wr_take) begin
            case (adr)
                ppg_pkg::OFF_LOW_CTL: begin
                    st_nxt.lower_timer_control = wbyte;
                end
                ppg_pkg::OFF_UP_CTL: begin
                    st_nxt.upper_timer_control = wbyte;
                end
                ppg_pkg::OFF_PER_LO: begin
                    st_nxt.period_low_byte = wbyte;
                end
                ppg_pkg::OFF_PER_HI: begin
                    st_nxt.period_high_byte = wbyte;
                end
                ppg_pkg::OFF_WID_LO: begin
                    st_nxt.width_low_byte = wbyte;
                end
                ppg_pkg::OFF_WID_HI: begin
                    st_nxt.width_high_byte = wbyte;
                end
                default: begin
                    st_nxt.rdata = st_r.rdata;
                end
            endcase
        end

        if (run) begin
            if (tick && pulse_mode) begin
                if (per_hit) begin
                    st_nxt.count       = ppg_pkg::RST_COUNT;
                    st_nxt.output_flop = ~st_r.output_flop;
                    st_nxt.irq         = 1'b1;
                end else if (wid_hit) begin
                    st_nxt.count       = cnt_inc;
                    st_nxt.output_flop = ~st_r.output_flop;
                end else begin
                    st_nxt.count = cnt_inc;
                end
            end else if (tick && warm_mode) begin
                if (warm_hit) begin
                    st_nxt.count = ppg_pkg::RST_COUNT;
                    st_nxt.irq   = 1'b1;
                end else begin
                    st_nxt.count = cnt_inc;
                end
            end
        end else begin
            // Stopped: flop holds unless a control write loads it
            if (ctl_write) begin
                st_nxt.output_flop = wbyte[ppg_pkg::UP_START_BIT];
            end
            if (ctl_write && wbyte[ppg_pkg::UP_RUN_BIT]) begin
                st_nxt.count = ppg_pkg::RST_COUNT;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r.ack                 <= 1'b0;
            st_r.rdata               <= 32'h0000_0000;
            st_r.lower_timer_control <= ppg_pkg::RST_CTL;
            st_r.upper_timer_control <= ppg_pkg::RST_CTL;
            st_r.period_low_byte     <= ppg_pkg::RST_CMP;
            st_r.period_high_byte    <= ppg_pkg::RST_CMP;
            st_r.width_low_byte      <= ppg_pkg::RST_CMP;
            st_r.width_high_byte     <= ppg_pkg::RST_CMP;
            st_r.count               <= ppg_pkg::RST_COUNT;
            st_r.output_flop         <= 1'b0;
            st_r.irq                 <= 1'b0;
            st_r.pre                 <= ppg_pkg::RST_PRE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o          = st_r.ack;
    assign wb_dat_o          = st_r.rdata;
    assign pulse_out_pin     = ~st_r.output_flop;
    assign cascade_match_irq = st_r.irq;

endmodule // cascaded_ppg_warmup_timer

// ---- tb/timer_asserts.sv ----
// Port checker for the cascaded timer
`timescale 1ns/100ps
module timer_asserts (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        slow_tick,
    input wire logic        count_pin,
    input wire logic        pulse_out_pin,
    input wire logic        cascade_match_irq
);
    logic run_r;
    logic wr_up;
    assign wr_up = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i[4:0] == ppg_pkg::OFF_UP_CTL;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            run_r <= 1'b0;
        else if (wr_up)
            run_r <= wb_dat_i[ppg_pkg::UP_RUN_BIT];
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    pin_reset_a: assert property ($fell(rst) |-> pulse_out_pin && !cascade_match_irq)
        else $error("pin or irq wrong after reset");
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    irq_single_a: assert property (cascade_match_irq |=> !cascade_match_irq)
        else $error("irq too long");
    irq_stopped_a: assert property (!run_r && !$past(wr_up) |-> !cascade_match_irq)
        else $error("irq while stopped");
    pin_hold_a: assert property (!run_r && !wr_up && !$past(wr_up) |=> $stable(pulse_out_pin))
        else $error("pin moved while stopped");
    level_low_a: assert property (wr_up && !run_r && !wb_dat_i[7] |-> ##[1:2] pulse_out_pin)
        else $error("pin not high");
    level_high_a: assert property (wr_up && !run_r && wb_dat_i[7] |-> ##[1:2] !pulse_out_pin)
        else $error("pin not low");
endmodule // timer_asserts

// ---- tb/count_source.sv ----
// External count source for the count pin
`timescale 1ns/100ps
module count_source #(parameter int HOLD = 8) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic en,
    output logic      count_pin
);
    int n;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            n <= 0;
            count_pin <= 1'b1;
        end else if (en) begin
            n <= (n == HOLD - 1) ? 0 : n + 1;
            if (n == HOLD - 1)
                count_pin <= !count_pin;
        end
    end
endmodule // count_source

// ---- tb/testbench.sv ----
// Register level tests of the cascaded timer
`timescale 1ns/100ps
module testbench;
    localparam logic [4:0] UP = ppg_pkg::OFF_UP_CTL;
    localparam logic [4:0] LC = ppg_pkg::OFF_LOW_CTL;
    localparam logic [4:0] ST = ppg_pkg::OFF_STATUS;
    logic        sys_clk, rst, cyc, stb, we, slow_tick, en, slow_on;
    logic [3:0]  sel;
    logic [31:0] adr, dat, q, dat_o;
    logic        ack, pin, irq, cpin, hold;
    int          mismatches, checked, n, lows, sc;
    logic [4:0]  offs [9] = '{ppg_pkg::OFF_LOW_CTL, ppg_pkg::OFF_UP_CTL, ppg_pkg::OFF_PER_LO,
        ppg_pkg::OFF_PER_HI, ppg_pkg::OFF_WID_LO, ppg_pkg::OFF_WID_HI, ppg_pkg::OFF_STATUS,
        ppg_pkg::OFF_COUNT, 5'h02};
    logic [7:0]  exps [9] = '{ppg_pkg::RST_CTL, ppg_pkg::RST_CTL, ppg_pkg::RST_CMP,
        ppg_pkg::RST_CMP, ppg_pkg::RST_CMP, ppg_pkg::RST_CMP, 8'h00, 8'h00, 8'h00};
    logic [7:0]  srcs [8] = '{8'h60, 8'h70, 8'h40, 8'h50, 8'h30, 8'h20, 8'h10, 8'h00};
    int          tks [8] = '{1, 16, 10, 2, 8, 32, 128, 2048};
    int          pw [2] = '{3, 1};
    int          pp [2] = '{8, 4};
    cascaded_ppg_warmup_timer dut_u (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .slow_tick(slow_tick), .count_pin(cpin),
        .pulse_out_pin(pin), .cascade_match_irq(irq));
    count_source #(.HOLD(8)) src_u (.sys_clk(sys_clk), .rst(rst), .en(en), .count_pin(cpin));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (rst) begin
            sc <= 0;
            slow_tick <= 1'b0;
        end else begin
            sc <= (sc == 9) ? 0 : sc + 1;
            slow_tick <= (sc == 9) && slow_on;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {27'h0000000, a};
        dat <= {24'h000000, d};
        do begin
            @(posedge sys_clk);
        end while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr16(input logic [4:0] a, input logic [15:0] v);
        bus(1'b1, a, v[7:0]);
        bus(1'b1, a + 5'h04, v[15:8]);
    endtask
    task automatic wait_irq;
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (irq !== 1'b1 && k < 10000);
        n = k;
        if (k >= 10000) begin
            mismatches++;
            final_report();
        end
    endtask
    task automatic final_report;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        {cyc, stb, we, en, slow_on} = 5'h00;
        sel = 4'hF;
        adr = 32'h00000000;
        dat = 32'h00000000;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        check(pin, 1'b1);
        foreach (offs[i]) begin
            bus(1'b0, offs[i], 8'h00);
            check(q, {24'h000000, exps[i]});
        end
        $display("test reset done");
        foreach (pw[i]) begin
            bus(1'b1, UP, 8'h57);
            bus(1'b1, UP, 8'h57);
            wr16(ppg_pkg::OFF_WID_LO, pw[i][15:0]);
            wr16(ppg_pkg::OFF_PER_LO, pp[i][15:0]);
            bus(1'b1, LC, 8'h60);
            bus(1'b1, UP, 8'h5F);
            wait_irq();
            wait_irq();
            check(n, pp[i]);
            lows = 0;
            repeat (pp[i]) begin
                @(posedge sys_clk);
                if (pin === 1'b0) lows++;
            end
            check(lows, pp[i] - pw[i]);
        end
        $display("test pulse done");
        bus(1'b1, UP, 8'h57);
        bus(1'b0, ST, 8'h00);
        check(q[ppg_pkg::ST_RUN_BIT], 1'b0);
        hold = pin;
        repeat (20) @(posedge sys_clk);
        check(pin, hold);
        bus(1'b1, UP, 8'h97);
        repeat (2) @(posedge sys_clk);
        check(pin, 1'b0);
        bus(1'b0, ST, 8'h00);
        check(q[ppg_pkg::ST_FLOP_BIT], 1'b1);
        bus(1'b1, UP, 8'h17);
        repeat (2) @(posedge sys_clk);
        check(pin, 1'b1);
        $display("test stop done");
        wr16(ppg_pkg::OFF_WID_LO, 16'h0002);
        wr16(ppg_pkg::OFF_PER_LO, 16'h0004);
        en <= 1'b1;
        slow_on <= 1'b1;
        foreach (srcs[i]) begin
            bus(1'b1, UP, 8'h57);
            bus(1'b1, LC, srcs[i]);
            bus(1'b1, UP, 8'h5F);
            wait_irq();
            wait_irq();
            check(n, 4 * tks[i]);
        end
        $display("test sources done");
        bus(1'b1, UP, 8'h57);
        bus(1'b1, UP, 8'h05);
        bus(1'b1, LC, 8'h60);
        wr16(ppg_pkg::OFF_PER_LO, 16'h02FF);
        bus(1'b1, UP, 8'h0D);
        wait_irq();
        wait_irq();
        check(n, 512);
        bus(1'b1, UP, 8'h05);
        check(pin, 1'b1);
        bus(1'b1, LC, 8'h40);
        wr16(ppg_pkg::OFF_PER_LO, 16'(ppg_pkg::WARM_MIN_SET));
        bus(1'b1, UP, 8'h0D);
        wait_irq();
        wait_irq();
        check(n, ppg_pkg::WARM_MIN_SET * 10);
        bus(1'b1, UP, 8'h05);
        $display("test warmup done");
        final_report();
    end
    initial begin
        #5000000;
        mismatches++;
        final_report();
    end
endmodule // testbench
bind cascaded_ppg_warmup_timer timer_asserts chk_u (.*);
